// file: verilog/fcd_decoder.sv
`timescale 1ns/10ps
module fcd_decoder
(
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             instr_valid,
   input  wire logic [31:0]      instr_word,
   output logic                  dec_valid_q,
   output logic                  dec_is_fp_q,
   output fcd_pkg::fcd_op_t      dec_op_q,
   output fcd_pkg::fcd_cls_t     dec_cls_q,
   output fcd_pkg::fcd_fmt_t     dec_fmt_q,
   output logic                  ri_exc_q,
   output logic                  unimpl_exc_q
);
   import fcd_pkg::*;

   // ****************************************************************
   // field extraction
   // ****************************************************************
   logic [5:0]  opc;
   logic [4:0]  rs;
   logic [1:0]  rt_up;
   logic [2:0]  rt_lo;
   logic [5:0]  fn;

   assign opc   = instr_word[OPC_HI:OPC_LO];
   assign rs    = instr_word[RS_HI:RS_LO];
   assign rt_up = instr_word[RT_HI:RT_MID+1];
   assign rt_lo = instr_word[RT_MID:RT_LO];
   assign fn    = instr_word[FN_HI:FN_LO];

   // slots kept for unsupported wide multiply/divide, linked
   // load/store and second-coprocessor load/store
   function automatic logic unsup_slot
   (
      input logic [5:0] code
   );
      return (code[5:4] == UNS_TOP) && (code[0] == UNS_LSB);
   endfunction

   function automatic logic is_fmt_sd
   (
      input logic [4:0] sel
   );
      return (sel == RS_SINGLE) || (sel == RS_DOUBLE);
   endfunction

   function automatic logic is_fmt_wl
   (
      input logic [4:0] sel
   );
      return (sel == RS_WORD) || (sel == RS_LONG);
   endfunction

   // ****************************************************************
   // function-field map
   // ****************************************************************
   fcd_map_if map_if ();

   assign map_if.is_wl = is_fmt_wl(rs);
   assign map_if.func  = fn;

   fcd_func_map u_map
   (
      .m (map_if.map)
   );

   // ****************************************************************
   // decode
   // ****************************************************************
   logic        valid_d;
   logic        is_fp_d;
   fcd_op_t     op_d;
   fcd_cls_t    cls_d;
   fcd_fmt_t    fmt_d;
   logic        ri_d;
   logic        un_d;

   always_comb
   begin
      valid_d = instr_valid;
      is_fp_d = 1'b0;
      op_d    = op_none;
      cls_d   = cls_pass;
      fmt_d   = fmt_none;
      if (!instr_valid)
      begin
         cls_d = cls_pass;
      end
      else if (unsup_slot(opc))
      begin
         cls_d = cls_unsupported;
      end
      else if (opc == MAJ_FP_COPROC)
      begin
         is_fp_d = 1'b1;
         if (rs == RS_BRANCH)
         begin
            // class code: resolved here from the rt selector, not through the function map
            fmt_d = fmt_branch;
            cls_d = cls_reserved;
            if (rt_up == BR_UP_ZERO && rt_lo == BR_LOW_F)
            begin
               op_d  = branch_on_cond_false;
               cls_d = cls_valid;
            end
            else if (rt_up == BR_UP_ZERO && rt_lo == BR_LOW_T)
            begin
               op_d  = branch_on_cond_true;
               cls_d = cls_valid;
            end
         end
         else if (is_fmt_sd(rs) || is_fmt_wl(rs))
         begin
            case (rs)
               RS_SINGLE: fmt_d = fmt_single;
               RS_DOUBLE: fmt_d = fmt_double;
               RS_WORD:   fmt_d = fmt_word;
               default:   fmt_d = fmt_long;
            endcase
            op_d  = map_if.op;
            cls_d = map_if.cls;
         end
         else if (rs[4:3] == RS_ROW_MOVE)
         begin
            // register moves are executed by the transfer path
            if (rs[2:0] == MOVE_RSV_A || rs[2:0] == MOVE_RSV_B)
            begin
               cls_d = cls_reserved;
            end
            else
            begin
               op_d  = op_fp_xfer;
               cls_d = cls_valid;
            end
         end
         else if (rs[4:3] == RS_ROW_BR)
         begin
            cls_d = cls_reserved;
         end
         else
         begin
            cls_d = cls_unimpl;
         end
      end
   end

   // the unsupported slots share the reserved-instruction trap
   assign ri_d = (cls_d == cls_reserved)
              || (cls_d == cls_unsupported);
   // flagged always, so software can emulate the missing encoding
   assign un_d = (cls_d == cls_unimpl);

   // ****************************************************************
   // result register
   // ****************************************************************
   // op and class leave in the same register stage, never skewed
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dec_valid_q  <= 1'b0;
         dec_is_fp_q  <= 1'b0;
         dec_op_q     <= op_none;
         dec_cls_q    <= cls_pass;
         dec_fmt_q    <= fmt_none;
         ri_exc_q     <= 1'b0;
         unimpl_exc_q <= 1'b0;
      end
      else
      begin
         dec_valid_q  <= valid_d;
         dec_is_fp_q  <= is_fp_d;
         dec_op_q     <= op_d;
         dec_cls_q    <= cls_d;
         dec_fmt_q    <= fmt_d;
         ri_exc_q     <= ri_d;
         unimpl_exc_q <= un_d;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   logic cop_in;

   assign cop_in = instr_valid && opc == MAJ_FP_COPROC;

   unsup_trap_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      instr_valid && unsup_slot(opc)
      |=> dec_cls_q == cls_unsupported && ri_exc_q && !dec_is_fp_q)
      else $error("unsupported slot did not trap");

   cop_route_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      cop_in && rs == RS_DOUBLE
      |=> dec_is_fp_q && dec_fmt_q == fmt_double)
      else $error("coprocessor word not routed by format");

   br_false_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      cop_in && rs == RS_BRANCH && rt_up == BR_UP_ZERO && rt_lo == 3'h0
      |=> dec_op_q == branch_on_cond_false && dec_cls_q == cls_valid)
      else $error("false branch misdecoded");

   br_reserved_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      cop_in && rs == RS_BRANCH && (rt_up != BR_UP_ZERO || rt_lo > 3'h1)
      |=> dec_cls_q == cls_reserved && ri_exc_q && dec_op_q == op_none)
      else $error("branch selector not reserved");

   arith_map_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      cop_in && rs == RS_SINGLE && fn == 6'h02
      |=> dec_op_q == product_op && dec_fmt_q == fmt_single)
      else $error("arithmetic group misdecoded");

   round_map_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      cop_in && rs == RS_DOUBLE && fn == 6'h0d
      |=> dec_op_q == chop_to_word && dec_cls_q == cls_valid)
      else $error("rounding group misdecoded");

   conv_hole_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      cop_in && is_fmt_sd(rs) && fn[5:3] == FG_CONV
      && (fn[2:0] == 3'h2 || fn[2:0] == 3'h3 || fn[2:1] == 2'h3)
      |=> dec_cls_q == cls_unimpl && unimpl_exc_q && !ri_exc_q)
      else $error("conversion hole not unimplemented");

   cmp_map_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      cop_in && is_fmt_sd(rs) && fn == 6'h30
      |=> dec_op_q == pred_false && dec_cls_q == cls_valid)
      else $error("compare group misdecoded");

   scmp_map_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      cop_in && rs == RS_SINGLE && fn == 6'h3f
      |=> dec_op_q == pred_not_greater && dec_cls_q == cls_valid)
      else $error("signalling compare misdecoded");

   grp_hole_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      cop_in && is_fmt_sd(rs)
      && (fn[5:3] == 3'h2 || fn[5:3] == 3'h3 || fn[5:3] == 3'h5)
      |=> dec_cls_q == cls_unimpl && dec_op_q == op_none)
      else $error("empty group not unimplemented");

   wl_map_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      cop_in && is_fmt_wl(rs) && fn[5:1] != 5'h10
      |=> dec_cls_q == cls_unimpl && unimpl_exc_q)
      else $error("word/long accepted a bad function");

   rsv_exc_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      dec_cls_q == cls_reserved |-> ri_exc_q && !unimpl_exc_q)
      else $error("reserved without trap");

   class_res_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      cop_in && is_fmt_sd(rs)
      |=> dec_cls_q != cls_pass
          && (dec_op_q != op_none || dec_cls_q == cls_unimpl))
      else $error("class encoding left unresolved");

   idle_out_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !instr_valid
      |=> !dec_valid_q && dec_cls_q == cls_pass && dec_op_q == op_none
          && !ri_exc_q && !unimpl_exc_q)
      else $error("idle cycle produced a result");

endmodule

// file: include/fcd_pkg.sv
package fcd_pkg;

   // ****************************************************************
   // instruction word fields
   // ****************************************************************
   localparam int OPC_HI = 31;
   localparam int OPC_LO = 26;
   localparam int RS_HI  = 25;
   localparam int RS_LO  = 21;
   localparam int RT_HI  = 20;
   localparam int RT_MID = 18;
   localparam int RT_LO  = 16;
   localparam int FN_HI  = 5;
   localparam int FN_LO  = 0;

   // ****************************************************************
   // major opcode and format selector values
   // ****************************************************************
   localparam logic [5:0] MAJ_FP_COPROC = 6'h11;
   localparam logic [1:0] UNS_TOP       = 2'h3;
   localparam logic       UNS_LSB       = 1'h0;
   localparam logic [4:0] RS_BRANCH     = 5'h08;
   localparam logic [4:0] RS_SINGLE     = 5'h10;
   localparam logic [4:0] RS_DOUBLE     = 5'h11;
   localparam logic [4:0] RS_WORD       = 5'h14;
   localparam logic [4:0] RS_LONG       = 5'h15;
   localparam logic [1:0] RS_ROW_MOVE   = 2'h0;
   localparam logic [1:0] RS_ROW_BR     = 2'h1;
   localparam logic [2:0] MOVE_RSV_A    = 3'h3;
   localparam logic [2:0] MOVE_RSV_B    = 3'h7;

   // ****************************************************************
   // branch selector and function groups
   // ****************************************************************
   localparam logic [1:0] BR_UP_ZERO = 2'h0;
   localparam logic [2:0] BR_LOW_F   = 3'h0;
   localparam logic [2:0] BR_LOW_T   = 3'h1;
   localparam logic [2:0] FG_ARITH   = 3'h0;
   localparam logic [2:0] FG_ROUND   = 3'h1;
   localparam logic [2:0] FG_CONV    = 3'h4;
   localparam logic [2:0] FG_CMP     = 3'h6;
   localparam logic [2:0] FG_SCMP    = 3'h7;
   localparam logic [2:0] CV_SINGLE  = 3'h0;
   localparam logic [2:0] CV_DOUBLE  = 3'h1;
   localparam logic [2:0] CV_WORD    = 3'h4;
   localparam logic [2:0] CV_LONG    = 3'h5;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum {
      op_none, op_fp_xfer,
      branch_on_cond_false, branch_on_cond_true,
      add_op, difference_op, product_op, quotient_op,
      root_op, magnitude_op, copy_op, sign_flip_op,
      near_to_long, chop_to_long, up_to_long, down_to_long,
      near_to_word, chop_to_word, up_to_word, down_to_word,
      conv_to_single, conv_to_double, conv_to_word, conv_to_long,
      pred_false, pred_unordered, pred_equal, pred_unord_or_eq,
      pred_ord_less, pred_unord_less, pred_ord_lesseq,
      pred_unord_lesseq,
      pred_sig_false, pred_not_gtlteq, pred_sig_equal, pred_not_gtlt,
      pred_less, pred_not_gteq, pred_lesseq, pred_not_greater
   } fcd_op_t;

   typedef enum {
      cls_pass, cls_valid, cls_reserved, cls_unimpl, cls_unsupported
   } fcd_cls_t;

   typedef enum {
      fmt_none, fmt_branch, fmt_single, fmt_double, fmt_word, fmt_long
   } fcd_fmt_t;

endpackage

// file: include/fcd_map_if.sv
`timescale 1ns/10ps
interface fcd_map_if;
   import fcd_pkg::*;
   logic          is_wl;
   logic [5:0]    func;
   fcd_op_t       op;
   fcd_cls_t      cls;

   modport dec (output is_wl, output func, input op, input cls);
   modport map (input is_wl, input func, output op, output cls);
endinterface

// file: verilog/fcd_func_map.sv
`timescale 1ns/10ps
module fcd_func_map
(
   fcd_map_if.map m
);
   import fcd_pkg::*;

   // groups are laid out in enum order, so an offset picks the member
   function automatic fcd_op_t grp_op
   (
      input fcd_op_t    first,
      input logic [2:0] low
   );
      return fcd_op_t'(int'(first) + int'(low));
   endfunction

   logic [2:0] hi;
   logic [2:0] lo;

   assign hi = m.func[5:3];
   assign lo = m.func[2:0];

   always_comb
   begin
      m.op  = op_none;
      m.cls = cls_unimpl;
      if (m.is_wl)
      begin
         if (hi == FG_CONV && lo == CV_SINGLE)
         begin
            m.op  = conv_to_single;
            m.cls = cls_valid;
         end
         else if (hi == FG_CONV && lo == CV_DOUBLE)
         begin
            m.op  = conv_to_double;
            m.cls = cls_valid;
         end
      end
      else
      begin
         case (hi)
            FG_ARITH:
            begin
               m.op  = grp_op(add_op, lo);
               m.cls = cls_valid;
            end
            FG_ROUND:
            begin
               m.op  = grp_op(near_to_long, lo);
               m.cls = cls_valid;
            end
            FG_CONV:
            begin
               m.cls = cls_valid;
               case (lo)
                  CV_SINGLE: m.op = conv_to_single;
                  CV_DOUBLE: m.op = conv_to_double;
                  CV_WORD:   m.op = conv_to_word;
                  CV_LONG:   m.op = conv_to_long;
                  default:   m.cls = cls_unimpl;
               endcase
            end
            FG_CMP:
            begin
               m.op  = grp_op(pred_false, lo);
               m.cls = cls_valid;
            end
            FG_SCMP:
            begin
               m.op  = grp_op(pred_sig_false, lo);
               m.cls = cls_valid;
            end
            default:
            begin
               // 010, 011 and 101 stay unimplemented
               m.op  = op_none;
               m.cls = cls_unimpl;
            end
         endcase
      end
   end

endmodule

// file: bench/fcd_issue_model.sv
`timescale 1ns/10ps
// ****************************************************************
// issue-side source: hands the decoder one word per cycle
// ****************************************************************
module fcd_issue_model
(
   input  wire logic        core_clk,
   input  wire logic        req_valid,
   input  wire logic [31:0] req_word,
   output logic             instr_valid,
   output logic [31:0]      instr_word
);
   initial
   begin
      instr_valid = 1'b0;
      instr_word  = 32'h0;
   end

   // a bubble never repeats the old word, so stale decode shows up
   always @(negedge core_clk)
   begin
      instr_valid <= req_valid;
      instr_word  <= req_valid ? req_word : ~instr_word;
   end
endmodule

// file: bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import fcd_pkg::*;

   typedef struct {
      logic     is_fp;
      fcd_op_t  op;
      fcd_cls_t cls;
      fcd_fmt_t fmt;
   } fcd_exp_t;

   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        req_valid = 1'b0;
   logic [31:0] req_word = 32'h0;
   logic        instr_valid;
   logic [31:0] instr_word;
   logic        dec_valid_q;
   logic        dec_is_fp_q;
   fcd_op_t     dec_op_q;
   fcd_cls_t    dec_cls_q;
   fcd_fmt_t    dec_fmt_q;
   logic        ri_exc_q;
   logic        unimpl_exc_q;
   int          miscompares = 0;
   int          checked = 0;
   integer      seed = 32'ha451d12f;

   initial
      forever #2.5 core_clk = ~core_clk;

   fcd_issue_model src_u (.core_clk(core_clk), .req_valid(req_valid),
      .req_word(req_word), .instr_valid(instr_valid),
      .instr_word(instr_word));

   fcd_decoder dut_u (.core_clk(core_clk), .rst_n(rst_n),
      .instr_valid(instr_valid), .instr_word(instr_word),
      .dec_valid_q(dec_valid_q), .dec_is_fp_q(dec_is_fp_q),
      .dec_op_q(dec_op_q), .dec_cls_q(dec_cls_q), .dec_fmt_q(dec_fmt_q),
      .ri_exc_q(ri_exc_q), .unimpl_exc_q(unimpl_exc_q));

   // ****************************************************************
   // expected decode, worked out from the opcode maps
   // ****************************************************************
   function automatic fcd_exp_t expect_of(logic [31:0] w);
      fcd_exp_t   e;
      logic [4:0] rs;
      logic [2:0] lo;
      rs = w[25:21];
      lo = w[2:0];
      e.is_fp = 1'b0;
      e.op    = op_none;
      e.cls   = cls_pass;
      e.fmt   = fmt_none;
      if (w[31:26] == 6'h11)
      begin
         e.is_fp = 1'b1;
         e.cls   = cls_unimpl;
         if (rs == 5'h08)
         begin
            e.fmt = fmt_branch;
            e.cls = cls_reserved;
            if (w[20:17] == 4'h0)
            begin
               e.cls = cls_valid;
               e.op  = w[16] ? branch_on_cond_true : branch_on_cond_false;
            end
         end
         else if (rs == 5'h10 || rs == 5'h11)
         begin
            e.fmt = rs[0] ? fmt_double : fmt_single;
            e.cls = cls_valid;
            case (w[5:3])
               3'h0: e.op = fcd_op_t'(int'(add_op) + int'(lo));
               3'h1: e.op = fcd_op_t'(int'(near_to_long) + int'(lo));
               3'h4:
               begin
                  if (lo[1])
                     e.cls = cls_unimpl;
                  else
                     e.op = fcd_op_t'(int'(conv_to_single)
                                      + int'({lo[2], lo[0]}));
               end
               3'h6: e.op = fcd_op_t'(int'(pred_false) + int'(lo));
               3'h7: e.op = fcd_op_t'(int'(pred_sig_false) + int'(lo));
               default: e.cls = cls_unimpl;
            endcase
         end
         else if (rs == 5'h14 || rs == 5'h15)
         begin
            e.fmt = rs[0] ? fmt_long : fmt_word;
            if (w[5:1] == 5'h10)
            begin
               e.cls = cls_valid;
               e.op  = w[0] ? conv_to_double : conv_to_single;
            end
         end
         else if (rs[4:3] == 2'h0)
         begin
            e.cls = (rs[1:0] == 2'h3) ? cls_reserved : cls_valid;
            e.op  = (rs[1:0] == 2'h3) ? op_none : op_fp_xfer;
         end
         else if (rs[4:3] == 2'h1)
            e.cls = cls_reserved;
      end
      else if (w[31:30] == 2'h3 && w[26] == 1'b0)
         e.cls = cls_unsupported;
      return e;
   endfunction

   function automatic logic [31:0] cop(logic [4:0] rs, logic [4:0] rt,
                                       logic [5:0] fn);
      logic [31:0] r;
      r = $random(seed);
      return {6'h11, rs, rt, r[9:0], fn};
   endfunction

   // ****************************************************************
   // comparisons and report
   // ****************************************************************
   task automatic fail(logic [31:0] got, logic [31:0] exp);
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
   endtask

   task automatic cmp_bit(logic got, logic exp);
      checked++;
      if (got !== exp)
         fail(32'(got), 32'(exp));
   endtask

   task automatic cmp_op(fcd_op_t got, fcd_op_t exp);
      checked++;
      if (got !== exp)
         fail(32'(got), 32'(exp));
   endtask

   task automatic cmp_cls(fcd_cls_t got, fcd_cls_t exp);
      checked++;
      if (got !== exp)
         fail(32'(got), 32'(exp));
   endtask

   task automatic cmp_fmt(fcd_fmt_t got, fcd_fmt_t exp);
      checked++;
      if (got !== exp)
         fail(32'(got), 32'(exp));
   endtask

   task automatic check(logic v, logic [31:0] w);
      fcd_exp_t e;
      logic     trap;
      e = expect_of(w);
      if (!v)
      begin
         e.is_fp = 1'b0;
         e.cls   = cls_pass;
         e.op    = op_none;
         e.fmt   = fmt_none;
      end
      trap = e.cls == cls_reserved || e.cls == cls_unsupported;
      cmp_bit(dec_valid_q, v);
      cmp_cls(dec_cls_q, e.cls);
      cmp_bit(ri_exc_q, trap);
      cmp_bit(unimpl_exc_q, e.cls == cls_unimpl);
      if (e.cls == cls_valid || e.cls == cls_pass)
         cmp_op(dec_op_q, e.op);
      cmp_bit(dec_is_fp_q, e.is_fp);
      cmp_fmt(dec_fmt_q, e.fmt);
   endtask

   // result is looked at one edge after the word is taken
   task automatic send(logic v, logic [31:0] w);
      req_valid = v;
      req_word  = w;
      @(negedge core_clk);
      @(posedge core_clk);
      #1;
      check(v, w);
   endtask

   task automatic complete_run;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (100000) @(posedge core_clk);
      miscompares++;
      complete_run();
   end

   // ****************************************************************
   // scenarios
   // ****************************************************************
   initial
   begin
      logic [31:0] r;
      logic [31:0] w;
      repeat (8) @(negedge core_clk);
      check(1'b0, 32'h0);
      repeat (8) @(negedge core_clk);
      rst_n = 1'b1;
      $display("test reset done");
      for (int s = 0; s < 2; s++)
         for (int i = 0; i < 64; i++)
            send(1'b1, cop(5'h10 + 5'(s), 5'h0, 6'(i)));
      $display("test single_double done");
      for (int s = 0; s < 2; s++)
         for (int i = 0; i < 64; i++)
            send(1'b1, cop(5'h14 + 5'(s), 5'h0, 6'(i)));
      $display("test word_long done");
      for (int i = 0; i < 32; i++)
         send(1'b1, cop(5'h08, 5'(i), 6'($random(seed))));
      $display("test branch done");
      for (int i = 0; i < 32; i++)
      begin
         r = $random(seed);
         send(1'b1, cop(5'(i), r[4:0], r[10:5]));
      end
      $display("test format done");
      for (int i = 0; i < 64; i++)
      begin
         r = $random(seed);
         send(1'b1, {6'(i), r[25:0]});
      end
      $display("test major done");
      for (int i = 0; i < 400; i++)
      begin
         r = $random(seed);
         w = $random(seed);
         if (r[0])
            w[31:26] = 6'h11;
         if (r[1])
            w[25:24] = 2'h2;
         send(r[31:30] != 2'h0, w);
      end
      $display("test random done");
      send(1'b1, 32'h46000002);
      req_word = 32'h46000003;
      @(negedge core_clk);
      rst_n = 1'b0;
      #1;
      check(1'b0, 32'h0);
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      send(1'b1, 32'h46200003);
      $display("test mid_reset done");
      complete_run();
   end
endmodule
